// [src/irq_agg_pkg.sv]
package irq_agg_pkg;

    // Register bus shape
    localparam int ADR_W = 32;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int IDX_W = 30;

    // Number of primary summary slots, one per source block except slot 3
    localparam int NUM_PRIM = 16;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PRIMARY_STATUS = 30'h0000_4010;
    localparam logic [IDX_W-1:0] IDX_PIN_CONFIG = 30'h0000_4017;
    localparam logic [IDX_W-1:0] IDX_PRIMARY_MASK = 30'h0000_4018;
    // Secondary status and mask windows, block number in low four bits
    localparam logic [IDX_W-1:0] IDX_SEC_STATUS_BASE = 30'h0000_4100;
    localparam logic [IDX_W-1:0] IDX_SEC_MASK_BASE = 30'h0000_4120;
    localparam int IDX_BLK_LSB = 0;
    localparam int IDX_BLK_W = 4;

    // Pin config field positions
    localparam int POS_PIN_OUTPUT_MASK = 0;
    localparam int POS_PIN_DRIVE_SELECT = 1;

    // Primary bit positions
    localparam int POS_POWER_STATE = 15;
    localparam int POS_THERMAL = 14;
    localparam int POS_GP_PIN = 13;
    localparam int POS_ON_BUTTON = 12;
    localparam int POS_WATCHDOG = 11;
    localparam int POS_TOUCH_DATA = 10;
    localparam int POS_PEN_DOWN = 9;
    localparam int POS_AUX_CONVERTER = 8;
    localparam int POS_POWER_PATH = 7;
    localparam int POS_CURRENT_SINK = 6;
    localparam int POS_CLOCK_CALENDAR = 5;
    localparam int POS_OTP_MEMORY = 4;
    localparam int POS_UNUSED = 3;
    localparam int POS_CHARGER = 2;
    localparam int POS_HIGH_CURRENT = 1;
    localparam int POS_UNDERVOLTAGE = 0;

    // Slots that exist; bit 3 has no source block
    localparam logic [NUM_PRIM-1:0] PRIM_USED = 16'hFFF7;

    // Values after reset
    localparam logic [1:0] PIN_CONFIG_RST = 2'h0;
    localparam logic [NUM_PRIM-1:0] PRIMARY_MASK_RST = 16'hFFFF;
    localparam logic SEC_MASK_RST_BIT = 1'h1;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [SEL_W-1:0] sel;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } wb_req_t;

    // Interrupt pin as output level plus enable
    typedef struct packed {
        logic level;
        logic oe;
    } pin_drive_t;

endpackage : irq_agg_pkg

// [src/two_level_irq_aggregator.sv]
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module two_level_irq_aggregator
    import irq_agg_pkg::*;
#(
    parameter int SEC_W = 16,
    parameter int ACT_W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire wb_req_t wb_req_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_PRIM-1:0][SEC_W-1:0] event_trig_i,
    input wire logic [ACT_W-1:0] action_req_i,
    output logic [ACT_W-1:0] action_o,
    output logic [NUM_PRIM-1:0] primary_o,
    output pin_drive_t irq_n_o
);

    typedef logic [NUM_PRIM-1:0][SEC_W-1:0] sec_arr_t;

    // Whole block state in one record
    typedef struct packed {
        sec_arr_t sec_stat;
        sec_arr_t sec_mask;
        logic [NUM_PRIM-1:0] prim_mask;
        logic pin_drive_select;
        logic pin_output_mask;
        logic [NUM_PRIM-1:0] prim;
        logic irq_level;
        logic irq_oe;
        logic ack;
        logic [DAT_W-1:0] rdata;
        logic [ACT_W-1:0] action;
    } state_t;

    state_t s;
    state_t next_s;
    sec_arr_t clr;
    sec_arr_t trig_used;
    logic [NUM_PRIM-1:0] prim_calc;
    logic pin_hit;
    logic req;
    logic wr;
    logic rd_sec;
    logic wr_prim;
    logic [DAT_W-1:0] wmask;
    logic [IDX_W-1:0] idx;
    logic [IDX_BLK_W-1:0] blk;

    // Byte enables to a bit mask over the word
    function automatic logic [DAT_W-1:0] lane_mask(
        input logic [SEL_W-1:0] sel
    );
        logic [DAT_W-1:0] m;
        m = '0;
        for (int b = 0; b < SEL_W; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction : lane_mask

    // Index falls in a 16-entry window starting at base
    function automatic logic in_window(
        input logic [IDX_W-1:0] i,
        input logic [IDX_W-1:0] base
    );
        return i[IDX_W-1:IDX_BLK_W] == base[IDX_W-1:IDX_BLK_W];
    endfunction : in_window

    // Summary of unmasked secondaries per slot
    function automatic logic [NUM_PRIM-1:0] prim_of(
        input sec_arr_t st,
        input sec_arr_t mk
    );
        logic [NUM_PRIM-1:0] p;
        p = '0;
        for (int k = 0; k < NUM_PRIM; k++) begin
            p[k] = |(st[k] & ~mk[k]);
        end
        return p & PRIM_USED;
    endfunction : prim_of

    // Bus request decode
    assign idx = wb_req_i.adr[ADR_W-1:2];
    assign blk = idx[IDX_BLK_LSB +: IDX_BLK_W];
    // Ack in flight blocks a second take of a still-held strobe
    assign req = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
    assign wr = req & wb_req_i.we;
    assign wmask = lane_mask(wb_req_i.sel);
    assign rd_sec = req & ~wb_req_i.we & in_window(idx, IDX_SEC_STATUS_BASE);
    assign wr_prim = wr & (idx == IDX_PRIMARY_STATUS);

    // Triggers of the unused slot never reach a register
    generate
        for (genvar g = 0; g < NUM_PRIM; g++) begin : g_trig
            assign trig_used[g] = event_trig_i[g] & {SEC_W{PRIM_USED[g]}};
        end
    endgenerate

    // Next state
    always_comb begin
        next_s = s;
        clr = '0;
        prim_calc = prim_of(s.sec_stat, s.sec_mask);
        pin_hit = |(prim_calc & ~s.prim_mask);
        next_s.prim = prim_calc;

        if (s.pin_output_mask) begin
            next_s.irq_level = 1'h1;
            next_s.irq_oe = ~s.pin_drive_select;
        end else if (s.pin_drive_select) begin
            next_s.irq_level = 1'h0;
            next_s.irq_oe = pin_hit;
        end else begin
            next_s.irq_level = ~pin_hit;
            next_s.irq_oe = 1'h1;
        end

        // Single-cycle ack; dropped in the cycle after
        next_s.ack = req;
        next_s.rdata = '0;
        if (req) begin
            if (idx == IDX_PRIMARY_STATUS) begin
                next_s.rdata[NUM_PRIM-1:0] = prim_calc;
            end else if (idx == IDX_PIN_CONFIG) begin
                next_s.rdata[POS_PIN_OUTPUT_MASK] = s.pin_output_mask;
                next_s.rdata[POS_PIN_DRIVE_SELECT] = s.pin_drive_select;
                if (wr && wmask[POS_PIN_OUTPUT_MASK]) begin
                    next_s.pin_output_mask =
                        wb_req_i.dat[POS_PIN_OUTPUT_MASK];
                end
                if (wr && wmask[POS_PIN_DRIVE_SELECT]) begin
                    next_s.pin_drive_select =
                        wb_req_i.dat[POS_PIN_DRIVE_SELECT];
                end
            end else if (idx == IDX_PRIMARY_MASK) begin
                next_s.rdata[NUM_PRIM-1:0] = s.prim_mask;
                if (wr) begin
                    next_s.prim_mask =
                        (s.prim_mask & ~wmask[NUM_PRIM-1:0]) |
                        (wb_req_i.dat[NUM_PRIM-1:0] & wmask[NUM_PRIM-1:0]);
                end
            end else if (in_window(idx, IDX_SEC_STATUS_BASE)) begin
                // plain read, no clear on read
                next_s.rdata[SEC_W-1:0] = s.sec_stat[blk];
                if (wr) begin
                    clr[blk] = wb_req_i.dat[SEC_W-1:0] & wmask[SEC_W-1:0];
                end
            end else if (in_window(idx, IDX_SEC_MASK_BASE)) begin
                next_s.rdata[SEC_W-1:0] = s.sec_mask[blk];
                if (wr) begin
                    next_s.sec_mask[blk] =
                        (s.sec_mask[blk] & ~wmask[SEC_W-1:0]) |
                        (wb_req_i.dat[SEC_W-1:0] & wmask[SEC_W-1:0]);
                end
            end
            // Unmapped index reads zero and ignores writes
        end

        // latch, masks do not gate setting
        for (int k = 0; k < NUM_PRIM; k++) begin
            // set is applied after the clear
            next_s.sec_stat[k] = (s.sec_stat[k] & ~clr[k]) | trig_used[k];
        end

        next_s.action = action_req_i;
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.sec_mask <= {(NUM_PRIM*SEC_W){SEC_MASK_RST_BIT}};
            s.prim_mask <= PRIMARY_MASK_RST;
            s.pin_output_mask <= PIN_CONFIG_RST[POS_PIN_OUTPUT_MASK];
            s.pin_drive_select <= PIN_CONFIG_RST[POS_PIN_DRIVE_SELECT];
            s.irq_level <= 1'h1;
            s.irq_oe <= 1'h1;
        end else begin
            s <= next_s;
        end
    end

    // Ports straight from the state register
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign action_o = s.action;
    // slot 3 forced to zero by the used mask
    assign primary_o = s.prim;
    assign irq_n_o.level = s.irq_level;
    assign irq_n_o.oe = s.irq_oe;

    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    // Checks sleep through reset; only the reset check opts out
    default disable iff (rst_i);

    a_sec_latch_set: assert property (
        (trig_used != '0) |=> ((s.sec_stat & $past(trig_used)) ==
                               $past(trig_used)))
        else $error("secondary did not latch trigger");

    // trigger sets even if fully masked
    a_masked_still_sets: assert property (
        ((trig_used & s.sec_mask) != '0) |=>
            ((s.sec_stat & $past(trig_used & s.sec_mask)) ==
             $past(trig_used & s.sec_mask)))
        else $error("masked secondary failed to set");

    // bit falls only where a one was written
    a_sec_clear_cause: assert property (
        ##1 ((~s.sec_stat & $past(s.sec_stat) & ~$past(clr)) == '0))
        else $error("secondary cleared without write one");

    // trigger coinciding with clear keeps bit set
    a_set_beats_clr: assert property (
        ((clr & trig_used) != '0) |=>
            ((s.sec_stat & $past(clr & trig_used)) ==
             $past(clr & trig_used)))
        else $error("same-cycle clear lost an event");

    // read leaves latched bits in place
    a_read_no_side: assert property (
        rd_sec |=> ((s.sec_stat & $past(s.sec_stat)) == $past(s.sec_stat)))
        else $error("read disturbed secondary bits");

    // primaries track unmasked secondaries one clock later
    a_prim_is_or: assert property (
        ##1 (s.prim == prim_of($past(s.sec_stat), $past(s.sec_mask))))
        else $error("primary not OR of unmasked secondaries");

    // a primary holds while any unmasked secondary stays
    a_prim_hold: assert property (
        ((s.prim & prim_of(s.sec_stat, s.sec_mask)) != '0) |=>
            ((s.prim & $past(s.prim & prim_of(s.sec_stat, s.sec_mask))) ==
             $past(s.prim & prim_of(s.sec_stat, s.sec_mask))))
        else $error("primary cleared early");

    // write to primary changes no config
    a_prim_read_only: assert property (
        wr_prim |=> ($stable(s.prim_mask) && $stable(s.pin_output_mask) &&
                     $stable(s.pin_drive_select) && $stable(s.sec_mask)))
        else $error("primary write had an effect");

    // push-pull level is NOR of unmasked primaries
    a_pin_push_pull: assert property (
        (!s.pin_output_mask && !s.pin_drive_select) |=>
            (s.irq_oe && (s.irq_level == !$past(pin_hit))))
        else $error("push-pull pin level wrong");

    a_pin_open_drain: assert property (
        (!s.pin_output_mask && s.pin_drive_select) |=>
            (!s.irq_level && (s.irq_oe == $past(pin_hit))))
        else $error("open-drain pin drive wrong");

    a_pin_masked: assert property (
        s.pin_output_mask |=> (s.irq_level || !s.irq_oe))
        else $error("masked pin asserted");

    // primary mask all ones right after reset
    a_mask_reset: assert property (
        // First edge has no earlier sample to look back on
        disable iff (1'b0)
        ##1 $past(rst_i) |-> (s.prim_mask == PRIMARY_MASK_RST))
        else $error("primary mask not all ones after reset");

    // action follows request whatever the masks
    a_action_pass: assert property (
        !rst_i |=> (action_o == $past(action_req_i)))
        else $error("action gated by interrupt state");

    // pin masks never steer the summary
    a_prim_mask_free: assert property (
        ($stable(s.sec_stat) && $stable(s.sec_mask)) |=> $stable(s.prim))
        else $error("primary moved with secondaries still");

    // a written one clears unless a trigger lands
    a_w1c_applies: assert property (
        (clr != '0) |=> ((s.sec_stat & $past(clr & ~trig_used)) == '0))
        else $error("write one left secondary set");

    // full-word write lands in the secondary mask
    a_sec_mask_write: assert property (
        (wr && in_window(idx, IDX_SEC_MASK_BASE) && wmask[SEC_W-1:0] == '1)
        |=> (s.sec_mask[$past(blk)] == $past(wb_req_i.dat[SEC_W-1:0])))
        else $error("secondary mask write lost");

    // full write sets the primary mask
    a_prim_mask_write: assert property (
        (wr && idx == IDX_PRIMARY_MASK && wmask[NUM_PRIM-1:0] == '1) |=>
            (s.prim_mask == $past(wb_req_i.dat[NUM_PRIM-1:0])))
        else $error("primary mask write lost");

    a_cfg_write: assert property (
        (wr && idx == IDX_PIN_CONFIG && wmask[1:0] == 2'h3) |=>
            ({s.pin_drive_select, s.pin_output_mask} ==
             $past(wb_req_i.dat[1:0])))
        else $error("pin config write lost");

    // status read returns the fresh summary
    a_prim_read: assert property (
        (req && !wb_req_i.we && idx == IDX_PRIMARY_STATUS) |=>
            (wb_dat_o == DAT_W'(s.prim)))
        else $error("primary status read wrong");

    a_slot_quiet: assert property (
        (s.sec_stat[POS_UNUSED] == '0) && !s.prim[POS_UNUSED])
        else $error("unused slot became active");

    // Taken request answered in the next cycle
    a_ack_follows: assert property (
        req |=> wb_ack_o)
        else $error("request not acknowledged");

    // Read data is zero outside the ack cycle
    a_rdata_idle: assert property (
        !wb_ack_o |-> (wb_dat_o == '0))
        else $error("read data outside ack");

    // Bus ack is one cycle wide
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    c_pin_pp_low: cover property (
        !s.pin_drive_select && s.irq_oe && !s.irq_level);
    c_pin_od_low: cover property (
        s.pin_drive_select && s.irq_oe);
    c_set_and_clr: cover property ((clr & trig_used) != '0);
    c_w1c_clears: cover property (
        ##1 ((~s.sec_stat & $past(s.sec_stat)) != '0));
    c_pin_masked: cover property (
        s.pin_output_mask && ((prim_calc & ~s.prim_mask) != '0));

endmodule : two_level_irq_aggregator

// [sim/host_pin_model.sv]
`timescale 1ns/1ps
// Host side of the interrupt line: a pull-up holds the wire high whenever
// the device lets go, so a released pin never reads as a stale low
module host_pin_model
    import irq_agg_pkg::*;
(
    input wire pin_drive_t drv_i,
    output wire logic pin_o
);
    assign pin_o = drv_i.oe ? drv_i.level : 1'b1;
endmodule : host_pin_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench
    import irq_agg_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_t req = '0;
    logic [15:0][15:0] trig = '0;
    logic act = 1'b0;
    logic act_last = 1'b0;
    logic [1:0] ok = 2'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic action_o;
    logic [15:0] primary_o;
    pin_drive_t irq_n_o;
    wire logic irq_pin;
    logic [31:0] seed = 32'h49A72B8B;
    logic [31:0] q;
    logic [15:0] sec [16];
    logic [15:0] smask [16];
    logic [15:0] pmask;
    logic [1:0] cfg;
    int n_fail = 0;
    int n_tests = 0;
    int b, k, op;
    logic [15:0] d;

    two_level_irq_aggregator two_level_irq_aggregator_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_trig_i(trig),
        .action_req_i(act), .action_o(action_o), .primary_o(primary_o),
        .irq_n_o(irq_n_o));
    host_pin_model host_pin_model_i (.drv_i(irq_n_o), .pin_o(irq_pin));

    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Summary as the host should see it; slot 3 never fires
    function automatic logic [15:0] exp_prim();
        logic [15:0] p;
        for (int i = 0; i < 16; i++) begin
            p[i] = |(sec[i] & ~smask[i]);
        end
        p[3] = 1'b0;
        return p;
    endfunction : exp_prim

    // Expected wire level and enable from summary, masks and config
    function automatic logic [1:0] exp_pin();
        logic any;
        any = |(exp_prim() & ~pmask) & ~cfg[0];
        return {~any, ~cfg[1] | any};
    endfunction : exp_pin

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; held until ack is seen at a rising edge
    task automatic wb(input logic we, input logic [IDX_W-1:0] idx,
                      input logic [15:0] dw);
        @(posedge ref_clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3,
                 adr: {idx, 2'h0}, dat: {16'h0, dw}};
        // No cycle count assumed; the watchdog ends a hang
        do begin
            @(posedge ref_clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        req <= '0;
    endtask : wb

    task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] e);
        wb(1'b0, idx, 16'h0);
        chk(q, {16'h0, e});
    endtask : rd

    // Settle three clocks, then look between edges
    task automatic check_pins();
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk({16'h0, primary_o}, {16'h0, exp_prim()});
        chk({30'h0, irq_pin, irq_n_o.oe}, {30'h0, exp_pin()});
    endtask : check_pins

    task automatic pulse(input int bb, input int kk, input int len);
        @(posedge ref_clk_i);
        trig[bb][kk] <= 1'b1;
        repeat (len) @(posedge ref_clk_i);
        trig <= '0;
        if (bb != 3) sec[bb][kk] = 1'b1;
    endtask : pulse

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // Action requests pass one clock later, masks or not
    always @(posedge ref_clk_i) begin
        ok <= {ok[0], ~rst_i};
        act_last <= act;
        act <= 1'(rnd());
        if (ok == 2'h3) chk({31'h0, action_o}, {31'h0, act_last});
    end

    // Watchdog; a healthy run needs well under this
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            sec[i] = '0;
            smask[i] = 16'hFFFF;
        end
        pmask = 16'hFFFF;
        cfg = 2'h0;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(IDX_PRIMARY_MASK, 16'hFFFF);
        rd(IDX_PIN_CONFIG, 16'h0000);
        rd(IDX_PRIMARY_STATUS, 16'h0000);
        rd(IDX_SEC_MASK_BASE + 30'h5, 16'hFFFF);
        rd(30'h0000_4000, 16'h0000);
        pulse(2, 4, 1);
        check_pins();
        // Host unmasks, services, clears
        wb(1'b1, IDX_PRIMARY_MASK, 16'h0000);
        pmask = 16'h0;
        wb(1'b1, IDX_SEC_MASK_BASE + 30'h2, 16'h0000);
        smask[2] = 16'h0;
        check_pins();
        wb(1'b1, IDX_PRIMARY_STATUS, 16'h0000);
        rd(IDX_PRIMARY_STATUS, 16'h0004);
        rd(IDX_SEC_STATUS_BASE + 30'h2, 16'h0010);
        rd(IDX_SEC_STATUS_BASE + 30'h2, 16'h0010);
        wb(1'b1, IDX_SEC_STATUS_BASE + 30'h2, 16'hFFEF);
        rd(IDX_SEC_STATUS_BASE + 30'h2, 16'h0010);
        // Trigger held across the clearing write
        @(posedge ref_clk_i);
        trig[2][4] <= 1'b1;
        wb(1'b1, IDX_SEC_STATUS_BASE + 30'h2, 16'h0010);
        trig <= '0;
        rd(IDX_SEC_STATUS_BASE + 30'h2, 16'h0010);
        wb(1'b1, IDX_SEC_STATUS_BASE + 30'h2, 16'h0010);
        sec[2] = 16'h0;
        check_pins();
        // Every drive and mask combination with a live event
        wb(1'b1, IDX_SEC_MASK_BASE + 30'hD, 16'hFFFE);
        smask[13] = 16'hFFFE;
        pulse(13, 0, 1);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, IDX_PIN_CONFIG, 16'(c));
            cfg = 2'(c);
            check_pins();
        end
        // Random mix of events, clears and mask changes
        for (int it = 0; it < 80; it++) begin
            b = int'(rnd() % 16);
            k = int'(rnd() % 16);
            op = int'(rnd() % 5);
            d = 16'(rnd());
            case (op)
                0: pulse(b, k, 1 + int'(rnd() % 3));
                1: begin
                    wb(1'b1, IDX_SEC_MASK_BASE + 30'(b), d);
                    smask[b] = d;
                end
                2: begin
                    wb(1'b1, IDX_PRIMARY_MASK, d);
                    pmask = d;
                end
                3: begin
                    wb(1'b1, IDX_PIN_CONFIG, {14'h0, d[1:0]});
                    cfg = d[1:0];
                end
                default: begin
                    wb(1'b1, IDX_SEC_STATUS_BASE + 30'(b), d);
                    sec[b] &= ~d;
                end
            endcase
            check_pins();
            rd(IDX_SEC_STATUS_BASE + 30'(b), sec[b]);
            rd(IDX_SEC_MASK_BASE + 30'(b), smask[b]);
            rd(IDX_PRIMARY_STATUS, exp_prim());
            rd(IDX_PRIMARY_MASK, pmask);
            rd(IDX_PIN_CONFIG, {14'h0, cfg});
        end
        end_sim();
    end
endmodule : testbench
